// [pwm_defs.svh]
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// Bus and datapath widths
`define ADDR_W        4
`define DATA_W        16
`define CNT_W         10
`define PIN_N         6
`define CH_N          3

// Register indices on the plain register port
`define REG_CTRL      4'h0
`define REG_TOP       4'h1
`define REG_CMP_A     4'h2
`define REG_CMP_B     4'h3
`define REG_CMP_D     4'h4
`define REG_OVERRIDE  4'h5
`define REG_PORT      4'h6
`define REG_DIR       4'h7
`define REG_STATUS    4'h8
`define REG_COUNT     4'h9

// Control register field positions
`define CTRL_EN_A     0
`define CTRL_EN_B     1
`define CTRL_EN_D     2
`define CTRL_SLOPE    3
`define CTRL_SIX      4
`define CTRL_COM_A    6
`define CTRL_COM_B    8
`define CTRL_COM_D    10

// Status register field positions
`define STAT_OVF      0
`define STAT_DOWN     1

// Reset values and counter limits
`define CTRL_RST      16'h0000
`define TOP_RST       10'h3FF
`define CMP_RST       10'h000
`define PIN_RST       6'h00
`define CNT_MAX       10'h3FF

`endif

// [pwm_pkg.sv]
package pwm_pkg;

  typedef enum logic [1:0] {
    COM_OFF    = 2'h0,
    COM_COMPL  = 2'h1,
    COM_NONINV = 2'h2,
    COM_INV    = 2'h3
  } com_t;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

endpackage

// [pwm_wave.sv]
`timescale 1ns/1ns
`include "pwm_defs.svh"

module pwm_wave (
  input  wire logic                clk,        // System clock
  input  wire logic                rst,        // Asynchronous reset, high
  input  wire logic                ce,         // Clock enable, freezes state
  input  wire logic                tick,       // Timer tick
  input  wire logic                en,         // Channel takes part in a PWM mode
  input  wire logic                six,        // Six-output mode active
  input  wire logic                dual,       // Dual-slope counting
  input  wire pwm_pkg::com_t       com,        // Output mode of this channel
  input  wire pwm_pkg::dir_t       dir,        // Current count direction
  input  wire logic [`CNT_W-1:0]   cnt,        // Current counter value
  input  wire logic [`CNT_W-1:0]   cmp,        // Compare value
  input  wire logic [`CNT_W-1:0]   top,        // Top value
  input  wire logic                bottom_evt, // Counter becomes zero this tick
  output logic                     wave        // Waveform output
);

  logic inv;
  logic compl_mode;
  logic match;
  logic pinned;

  assign inv        = (com == pwm_pkg::COM_INV);
  assign compl_mode = (com == pwm_pkg::COM_COMPL) && !six;
  assign match      = (cnt == cmp); // RL21
  // Extreme top values pin the dual-slope waveform to a fixed level outside six-output mode
  assign pinned     = !six && dual && ((top == `CMP_RST) || (top == `CNT_MAX));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wave <= 1'b0;
    end else if (ce && tick && en) begin // RL20
      if (pinned) begin
        wave <= (top == `CNT_MAX) ? !inv : inv; // RL8
      end else if (match) begin
        if (dual && !compl_mode) begin
          wave <= (dir == pwm_pkg::DIR_UP) ? inv : !inv; // RL4 RL17
        end else begin
          wave <= inv; // RL5 RL14
        end
      end else if (bottom_evt && (!dual || compl_mode)) begin
        wave <= !inv; // RL5 RL14
      end
    end
  end

endmodule

// [pwm_core.sv]
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "pwm_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: Enable plus slope select gives dual-slope mode
// RL2: Dual-slope counter runs zero to top to zero
// RL3: Top held one tick, then counter decrements
// RL4: Non-inverted clears upward, sets downward; inverted opposite
// RL5: Complementary clears on match, sets at zero
// RL6: Mode two non-inverted, three inverted, one complementary
// RL7: Dual-slope overflow flag sets at zero
// RL8: Top zero low, top max high, inverted opposite
// RL9: Nonzero output mode and output direction override port
// RL10: Compare values reach pins only when output
// RL11: Channel A enable plus six select gives six-output
// RL12: Channel A waveform drives all six pins
// RL13: Each override bit instantly picks waveform or port
// RL14: Six single-slope changes on match, opposite at wrap
// RL15: Single-slope counter clears tick after reaching top
// RL16: Six single-slope overflow sets on reaching top
// RL17: Six dual-slope changes upward match, opposite downward
// RL18: Six dual-slope overflow sets on reaching zero
// RL19: Zero channel mode disconnects pair; override bits gate
// RL20: Counter advances only on timer tick cycles
// RL21: Ten-bit compares evaluated on every tick
//////////////////////////////////////////////////////////////////////////////

module pwm_core (
  input  wire logic               MCLK,     // System clock, 100 MHz
  input  wire logic               RST,      // Asynchronous reset, active high
  input  wire logic               CE,       // Clock enable, freezes all state
  input  wire logic               TICK,     // Timer tick, same clock domain
  input  wire logic [`ADDR_W-1:0] ADDR,     // Register index
  input  wire logic [`DATA_W-1:0] WDATA,    // Write data
  input  wire logic               WR,       // Write strobe
  input  wire logic               RD,       // Read strobe
  output logic      [`DATA_W-1:0] RDATA,    // Read data, cycle after strobe
  output logic      [`PIN_N-1:0]  PIN_OUT,  // Compare pin levels
  output logic      [`PIN_N-1:0]  PIN_OE,   // Compare pin drive enables
  output logic                    OVF_FLAG, // Overflow flag
  output logic      [`CNT_W-1:0]  COUNT     // Counter value
);

  //////////////////////////////////////////////////////////////////////////
  // Registers
  // A low clock enable freezes every flop below, register port included

  logic [`DATA_W-1:0] ctrl_r;
  logic [`CNT_W-1:0]  top_r;
  logic [`CNT_W-1:0]  cmp_r [`CH_N];
  logic [`PIN_N-1:0]  ovr_r;
  logic [`PIN_N-1:0]  port_r;
  logic [`PIN_N-1:0]  ddr_r;
  logic               ovf_r;
  logic [`CNT_W-1:0]  cnt_r;
  logic [`CNT_W-1:0]  cnt_nxt;
  pwm_pkg::dir_t      dir_r;
  pwm_pkg::dir_t      dir_nxt;
  logic               ovf_evt;
  logic               bottom_evt;
  logic [`DATA_W-1:0] rdata_nxt;
  logic [`PIN_N-1:0]  pin_out_nxt;

  // Decoded control fields
  logic [`CH_N-1:0]   pwm_en;
  logic               slope_select;
  logic               six_channel_mode_select;
  logic               six_output_mode;
  logic               dual_slope;
  logic [`CH_N-1:0]   pfc_mode;
  pwm_pkg::com_t      com [`CH_N];
  logic [`CH_N-1:0]   wave;

  assign pwm_en[0]               = ctrl_r[`CTRL_EN_A];
  assign pwm_en[1]               = ctrl_r[`CTRL_EN_B];
  assign pwm_en[2]               = ctrl_r[`CTRL_EN_D];
  assign slope_select            = ctrl_r[`CTRL_SLOPE];
  assign six_channel_mode_select = ctrl_r[`CTRL_SIX];
  assign com[0] = pwm_pkg::com_t'(ctrl_r[`CTRL_COM_A+1:`CTRL_COM_A]);
  assign com[1] = pwm_pkg::com_t'(ctrl_r[`CTRL_COM_B+1:`CTRL_COM_B]);
  assign com[2] = pwm_pkg::com_t'(ctrl_r[`CTRL_COM_D+1:`CTRL_COM_D]);

  assign six_output_mode = pwm_en[0] && six_channel_mode_select; // RL11
  // Counting style is shared: one counter serves all channels
  assign dual_slope = slope_select && (six_output_mode || (pwm_en != 3'h0));

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic com_on(input pwm_pkg::com_t c);
    com_on = (c != pwm_pkg::COM_OFF);
  endfunction

  // Pick the pin source for a non six-output channel: true pin follows
  // any nonzero mode, the complement pin only the complementary one
  function automatic logic pfc_sel(input pwm_pkg::com_t c, input logic compl);
    if (compl) begin
      pfc_sel = (c == pwm_pkg::COM_COMPL);
    end else begin
      pfc_sel = com_on(c);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= `CTRL_RST;
      top_r  <= `TOP_RST;
    end else if (CE && WR) begin
      if (ADDR == `REG_CTRL) begin
        ctrl_r <= WDATA;
      end
      if (ADDR == `REG_TOP) begin
        top_r <= WDATA[`CNT_W-1:0];
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < `CH_N; c++) begin : g_cmp
      always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
          cmp_r[c] <= `CMP_RST;
        end else if (CE && WR && (ADDR == (`REG_CMP_A + 4'(c)))) begin
          cmp_r[c] <= WDATA[`CNT_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ovr_r  <= `PIN_RST;
      port_r <= `PIN_RST;
      ddr_r  <= `PIN_RST;
    end else if (CE && WR) begin
      if (ADDR == `REG_OVERRIDE) begin
        ovr_r <= WDATA[`PIN_N-1:0];
      end
      if (ADDR == `REG_PORT) begin
        port_r <= WDATA[`PIN_N-1:0];
      end
      if (ADDR == `REG_DIR) begin
        ddr_r <= WDATA[`PIN_N-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter
  // Both ends of the dual slope last one tick: the turn loads top-1 or 1
  // at once, so neither end is counted twice. Top is not double buffered;
  // a new top applies from the next tick on.

  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (TICK) begin // RL20
      if (dual_slope) begin
        case (dir_r)
          pwm_pkg::DIR_UP: begin
            // The >= guards against top being lowered below the count
            if (cnt_r >= top_r) begin
              dir_nxt = pwm_pkg::DIR_DOWN; // RL3
              cnt_nxt = (top_r == `CMP_RST) ? `CMP_RST : top_r - 10'h001; // RL2
            end else begin
              cnt_nxt = cnt_r + 10'h001; // RL2
            end
          end
          pwm_pkg::DIR_DOWN: begin
            if (cnt_r == `CMP_RST) begin
              dir_nxt = pwm_pkg::DIR_UP;
              cnt_nxt = (top_r == `CMP_RST) ? `CMP_RST : 10'h001; // RL2
            end else begin
              cnt_nxt = cnt_r - 10'h001;
            end
          end
          default: begin
            dir_nxt = pwm_pkg::DIR_UP;
            cnt_nxt = `CMP_RST;
          end
        endcase
      end else begin
        dir_nxt = pwm_pkg::DIR_UP;
        cnt_nxt = (cnt_r >= top_r) ? `CMP_RST : cnt_r + 10'h001; // RL15
      end
    end
  end

  assign bottom_evt = TICK && (cnt_nxt == `CMP_RST);

  // Single slope flags the arrival at top, dual slope the arrival at zero
  always_comb begin
    ovf_evt = 1'b0;
    if (TICK) begin
      if (dual_slope) begin
        ovf_evt = (cnt_nxt == `CMP_RST); // RL7 RL18
      end else begin
        ovf_evt = (cnt_nxt == top_r); // RL16
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt_r <= `CMP_RST;
      dir_r <= pwm_pkg::DIR_UP;
    end else if (CE) begin
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end

  // A new overflow in the cycle of a clear keeps the flag set
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ovf_r <= 1'b0;
    end else if (CE) begin
      if (ovf_evt) begin
        ovf_r <= 1'b1; // RL7 RL16 RL18
      end else if (WR && (ADDR == `REG_STATUS) && WDATA[`STAT_OVF]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Waveform units
  // Units B and D sit idle in six-output mode and keep their last level

  generate
    for (c = 0; c < `CH_N; c++) begin : g_wave
      // Channel A also runs in six-output mode; B and D only in their own
      assign pfc_mode[c] = pwm_en[c] && slope_select && !six_output_mode; // RL1

      pwm_wave u_wave (
        .clk        (MCLK),
        .rst        (RST),
        .ce         (CE),
        .tick       (TICK),
        .en         (pfc_mode[c] || ((c == 0) && six_output_mode)),
        .six        (six_output_mode),
        .dual       (dual_slope),
        .com        (com[c]),
        .dir        (dir_r),
        .cnt        (cnt_r),
        .cmp        (cmp_r[c]),
        .top        (top_r),
        .bottom_evt (bottom_evt),
        .wave       (wave[c])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Pin routing
  // Override bits act at once with no period resync, so changing one
  // mid-period may leave a short pulse on that pin

  genvar p;
  generate
    for (p = 0; p < `PIN_N; p++) begin : g_pin
      localparam int CH = p / 2;
      localparam bit CP = (p % 2) == 1;
      logic sel;
      logic val;

      always_comb begin
        if (six_output_mode) begin
          sel = com_on(com[CH]) && ovr_r[p]; // RL13 RL19
          val = CP ? !wave[0] : wave[0]; // RL12
        end else if (pfc_mode[CH]) begin
          sel = pfc_sel(com[CH], CP); // RL6 RL9
          val = CP ? !wave[CH] : wave[CH];
        end else begin
          sel = 1'b0;
          val = 1'b0;
        end
      end

      assign pin_out_nxt[p] = sel ? val : port_r[p]; // RL9 RL13
    end
  endgenerate

  // Pins are driven only when their direction bit says output
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PIN_OUT <= `PIN_RST;
      PIN_OE  <= `PIN_RST;
    end else if (CE) begin
      PIN_OUT <= pin_out_nxt;
      PIN_OE  <= ddr_r; // RL10
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register reads
  // Upper bits and unmapped indices read as zero

  always_comb begin
    rdata_nxt = 16'h0000;
    case (ADDR)
      `REG_CTRL:     rdata_nxt = ctrl_r;
      `REG_TOP:      rdata_nxt = {6'h00, top_r};
      `REG_CMP_A:    rdata_nxt = {6'h00, cmp_r[0]};
      `REG_CMP_B:    rdata_nxt = {6'h00, cmp_r[1]};
      `REG_CMP_D:    rdata_nxt = {6'h00, cmp_r[2]};
      `REG_OVERRIDE: rdata_nxt = {10'h000, ovr_r};
      `REG_PORT:     rdata_nxt = {10'h000, port_r};
      `REG_DIR:      rdata_nxt = {10'h000, ddr_r};
      `REG_STATUS:   rdata_nxt = {14'h0000, (dir_r == pwm_pkg::DIR_DOWN), ovf_r};
      `REG_COUNT:    rdata_nxt = {6'h00, cnt_r};
      default:       rdata_nxt = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RDATA <= 16'h0000;
    end else if (CE) begin
      RDATA <= RD ? rdata_nxt : 16'h0000;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      OVF_FLAG <= 1'b0;
      COUNT    <= `CMP_RST;
    end else if (CE) begin
      OVF_FLAG <= ovf_r;
      COUNT    <= cnt_r;
    end
  end

endmodule

// [pwm_core_monitor.sv]
`timescale 1ns/1ns
module pwm_core_monitor (
  input wire logic        MCLK,     // System clock
  input wire logic        RST,      // Asynchronous reset
  input wire logic        CE,       // Clock enable
  input wire logic        TICK,     // Timer tick
  input wire logic [3:0]  ADDR,     // Register index
  input wire logic [15:0] WDATA,    // Write data
  input wire logic        WR,       // Write strobe
  input wire logic        RD,       // Read strobe
  input wire logic [15:0] RDATA,    // Read data
  input wire logic [5:0]  PIN_OUT,  // Pin levels
  input wire logic [5:0]  PIN_OE,   // Pin drive enables
  input wire logic        OVF_FLAG, // Overflow flag
  input wire logic [9:0]  COUNT     // Counter copy
);
  logic [15:0] ctrl_r;
  logic [9:0]  top_r;
  logic [5:0]  ovr_r;
  logic [5:0]  port_r;
  logic        six;
  logic        dual;

  // Shadow of the written setup, so the mode is known from the ports alone
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= 16'h0000;
      top_r  <= 10'h3FF;
      ovr_r  <= 6'h00;
      port_r <= 6'h00;
    end else if (CE && WR) begin
      case (ADDR)
        4'h0: ctrl_r <= WDATA;
        4'h1: top_r <= WDATA[9:0];
        4'h5: ovr_r <= WDATA[5:0];
        4'h6: port_r <= WDATA[5:0];
        default: ;
      endcase
    end
  end
  assign six  = ctrl_r[0] & ctrl_r[4];
  assign dual = ctrl_r[3] & (six | (|ctrl_r[2:0]));

  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  //////////////////////////////////////////////////////////////////////////////
  count_tick_a: assert property ($changed(COUNT) |-> $past(TICK && CE, 2))
    else $error("counter moved without a tick");
  count_read_a: assert property (RD && ADDR == 4'h9 |=> RDATA == {6'h00, COUNT})
    else $error("counter read does not match counter");
  rdata_idle_a: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data outside read cycle");
  dual_turn_a: assert property (dual && $changed(COUNT) && $past(COUNT) == top_r
    |-> COUNT == top_r - 10'h001) else $error("dual slope did not turn at top");
  single_wrap_a: assert property (!ctrl_r[3] && $changed(COUNT) && $past(COUNT) == top_r
    |-> COUNT == 10'h000) else $error("single slope did not wrap after top");
  ovf_dual_a: assert property ($rose(OVF_FLAG) && dual |-> COUNT == 10'h000)
    else $error("dual overflow away from zero");
  ovf_single_a: assert property ($rose(OVF_FLAG) && !ctrl_r[3] |-> COUNT == top_r)
    else $error("single overflow away from top");
  dir_follow_a: assert property (CE && WR && ADDR == 4'h7 |-> ##2 PIN_OE == 6'($past(WDATA, 2)))
    else $error("drive enables do not follow direction");
  port_pass_a: assert property (ctrl_r[11:6] == 6'h00 && ctrl_r == $past(ctrl_r)
    |-> PIN_OUT == $past(port_r)) else $error("port value not on pins");
  six_override_a: assert property (six && ctrl_r == $past(ctrl_r)
    |-> ((PIN_OUT ^ $past(port_r)) & ~$past(ovr_r)) == 6'h00) else $error("override off ignored");
  six_shared_a: assert property (six && ctrl_r == $past(ctrl_r) && ovr_r == $past(ovr_r)
    && ovr_r[0] && ovr_r[2] && ctrl_r[7:6] != 2'h0 && ctrl_r[9:8] != 2'h0
    |-> PIN_OUT[2] == PIN_OUT[0]) else $error("pairs do not share one waveform");
  compl_pair_a: assert property (!six && ctrl_r[0] && ctrl_r[3] && ctrl_r[7:6] == 2'h1
    && ctrl_r == $past(ctrl_r) |-> PIN_OUT[1] != PIN_OUT[0]) else $error("pair not complementary");
endmodule

// [pwm_stage.sv]
`timescale 1ns/1ns
module pwm_stage (
  input  wire logic       clk, // System clock
  input  wire logic [5:0] drv, // Pin levels from the block
  input  wire logic [5:0] oe,  // Pin drive enables
  output logic      [5:0] pad  // Level seen by the power stage
);
  logic [5:0] float_r = 6'h00;

  // Undriven pads wander each cycle so a stale level never passes as driven
  always_ff @(posedge clk) begin
    float_r <= ~float_r;
  end
  assign pad = (drv & oe) | (float_r & ~oe);
endmodule

// [tb.sv]
`timescale 1ns/1ns
module tb;
  typedef int lows_t [6];
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        CE = 1'b1;
  logic        TICK = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [15:0] RDATA;
  logic [5:0]  PIN_OUT;
  logic [5:0]  PIN_OE;
  logic        OVF_FLAG;
  logic [9:0]  COUNT;
  logic [5:0]  pad;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #5 MCLK = ~MCLK;

  pwm_core dut (.MCLK(MCLK), .RST(RST), .CE(CE), .TICK(TICK), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .OVF_FLAG(OVF_FLAG),
    .COUNT(COUNT));
  pwm_stage stage (.clk(MCLK), .drv(PIN_OUT), .oe(PIN_OE), .pad(pad));

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_count(input int got, input int exp, input string what);
    n_compared++;
    if (got != exp) begin
      n_errors++;
      $display("FAIL %0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  task automatic check_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    cmp_word(RDATA, exp, "register read");
  endtask

  // Counts low pad samples over 144 ticks, a whole number of both periods
  // Stat is the status word after the run: overflow, then direction of the last count
  task automatic run(input logic [15:0] ctrl, input lows_t exp, input logic [15:0] stat);
    lows_t lows = '{default: 0};
    lows_t highs = '{default: 0};
    wr(4'h0, ctrl);
    TICK <= 1'b1;
    repeat (20) @(posedge MCLK);
    repeat (144) begin
      @(negedge MCLK);
      for (int i = 0; i < 6; i++) lows[i] += (pad[i] === 1'b0);
      for (int i = 0; i < 6; i++) highs[i] += (pad[i] === 1'b1);
    end
    @(posedge MCLK);
    TICK <= 1'b0;
    for (int i = 0; i < 6; i++) cmp_count(lows[i], exp[i], "pin low count");
    // A pad that is neither level would slip past a low count of zero
    for (int i = 0; i < 6; i++) cmp_count(lows[i] + highs[i], 144, "pin known count");
    check_reg(4'h8, stat);
    wr(4'h8, 16'h0001);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs();
    check_reg(4'h0, 16'h0000);
    check_reg(4'h1, 16'h03FF);
    check_reg(4'h2, 16'h0000);
    check_reg(4'h8, 16'h0000);
    check_reg(4'h9, 16'h0000);
    wr(4'hF, 16'hFFFF);
    check_reg(4'hF, 16'h0000);
  endtask

  task automatic t_pfc();
    wr(4'h1, 16'h0008);
    wr(4'h2, 16'h0003);
    wr(4'h6, 16'h0002);
    wr(4'h7, 16'h003F);
    check_reg(4'h2, 16'h0003);
    run(16'h0089, '{90, 0, 144, 144, 144, 144}, 16'h0001);
    run(16'h00C9, '{54, 0, 144, 144, 144, 144}, 16'h0001);
    run(16'h0049, '{108, 36, 144, 144, 144, 144}, 16'h0003);
  endtask

  task automatic t_dir_off();
    wr(4'h7, 16'h0000);
    run(16'h0089, '{72, 72, 72, 72, 72, 72}, 16'h0003);
    wr(4'h7, 16'h003F);
  endtask

  task automatic t_six();
    wr(4'h5, 16'h0035);
    run(16'h0391, '{80, 0, 80, 144, 144, 144}, 16'h0001);
    run(16'h0399, '{90, 0, 90, 144, 144, 144}, 16'h0001);
  endtask

  task automatic t_extremes();
    wr(4'h1, 16'h0000);
    run(16'h0089, '{144, 0, 144, 144, 144, 144}, 16'h0001);
    run(16'h00C9, '{0, 0, 144, 144, 144, 144}, 16'h0001);
    wr(4'h1, 16'h03FF);
    run(16'h0089, '{0, 0, 144, 144, 144, 144}, 16'h0000);
  endtask

  // Clock enable low: ticks and a write in that time must both be ignored
  task automatic t_freeze();
    @(posedge MCLK);
    CE <= 1'b0;
    TICK <= 1'b1;
    wr(4'h1, 16'h0010);
    @(posedge MCLK);
    CE <= 1'b1;
    TICK <= 1'b0;
    check_reg(4'h9, 16'h00A4);
    check_reg(4'h1, 16'h03FF);
  endtask

  initial begin
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    t_reset_regs();
    t_pfc();
    t_dir_off();
    t_six();
    t_extremes();
    t_freeze();
    print_verdict();
  end

  // Whole run needs about 1600 cycles
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
endmodule

bind pwm_core pwm_core_monitor mon (.MCLK(MCLK), .RST(RST), .CE(CE), .TICK(TICK), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .OVF_FLAG(OVF_FLAG), .COUNT(COUNT));
